// ==== ctbce_map.svh ====
// Purpose: Named constants of the transfer, bit and control execution unit
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef CTBCE_MAP_SVH
`define CTBCE_MAP_SVH

// Status register bit positions
`define CTBCE_FLAG_C          0
`define CTBCE_FLAG_Z          1
`define CTBCE_FLAG_N          2
`define CTBCE_FLAG_V          3
`define CTBCE_FLAG_S          4
`define CTBCE_FLAG_H          5
`define CTBCE_FLAG_T          6
`define CTBCE_FLAG_I          7

// Reset values and the one-address step
`define CTBCE_STATUS_RESET    8'h00
`define CTBCE_SP_RESET        16'h00FF
`define CTBCE_BYTE_ZERO       8'h00
`define CTBCE_ADDR_ZERO       16'h0000
`define CTBCE_ADDR_ONE        16'h0001

// Data space layout: below this address is internal memory
`define CTBCE_DM_INT_TOP      16'h0100
`define CTBCE_DM_DEPTH        256
`define CTBCE_DM_AW           8

// Register file and I/O space
`define CTBCE_RF_DEPTH        32
`define CTBCE_IO_DEPTH        64
`define CTBCE_Z_LO            5'h1E
`define CTBCE_Z_HI            5'h1F

`endif

// ==== ctbce_pkg.sv ====
// Purpose: Types of the transfer, bit and control execution unit
// Assumes: Nothing
// Notes:   Operation codes and sequencer states
package ctbce_pkg;

    typedef enum logic [4:0]
    {
        OP_NOP,
        OP_IO_IN,
        OP_IO_OUT,
        OP_PUSH,
        OP_POP,
        OP_LOAD_Z,
        OP_LOAD_AND_OR_MEM,
        OP_LOAD_AND_CLEARBITS_MEM,
        OP_LOAD_AND_XOR_MEM,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_BIT_TO_TRANSFER_FLAG,
        OP_TRANSFER_FLAG_TO_BIT,
        OP_OVERFLOW_FLAG_SET,
        OP_OVERFLOW_FLAG_CLEAR,
        OP_HALFCARRY_SET,
        OP_HALFCARRY_CLEAR,
        OP_SIGNTEST_SET,
        OP_SIGNTEST_CLEAR,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_BREAK,
        OP_SLEEP,
        OP_WATCHDOG_RESTART
    } ctbce_op_t;

    typedef enum logic [1:0]
    {
        S_IDLE,
        S_MEM,
        S_EXT
    } ctbce_state_t;

endpackage : ctbce_pkg

// ==== ctbce_dm_if.sv ====
// Purpose: Internal data memory port between sequencer and memory
// Assumes: One clock domain
// Notes:   Read data arrive one edge after the read strobe
`timescale 1ns/1ps
`default_nettype none
interface ctbce_dm_if;
    logic       ce;
    logic       re;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctl (output ce, output re, output we, output addr, output wdata, input rdata);
    modport mem (input ce, input re, input we, input addr, input wdata, output rdata);
endinterface : ctbce_dm_if
`default_nettype wire

// ==== ctbce_dmem.sv ====
// Purpose: Internal data memory, stack and pointer targets
// Assumes: Synchronous write, registered read
// Notes:   Write and read of one address in one edge returns the old byte
`timescale 1ns/1ps
`default_nettype none
module ctbce_dmem
    import ctbce_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    ctbce_dm_if.mem    dm
);
`include "ctbce_map.svh"

    logic [7:0] mem_r [0:`CTBCE_DM_DEPTH-1];
    logic [7:0] rdata_r;

    always_ff @(posedge clk)
    begin
        if (dm.ce && dm.we)
        begin
            mem_r[dm.addr] <= dm.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_r <= `CTBCE_BYTE_ZERO;
        end
        else if (dm.ce && dm.re)
        begin
            rdata_r <= mem_r[dm.addr];
        end
    end

    assign dm.rdata = rdata_r;

endmodule : ctbce_dmem
`default_nettype wire

// ==== ctbce_core.sv ====
// Purpose: Execution unit for transfer, bit and control operations
// Assumes: One operation at a time, taken while OP_READY is high
// Notes:   Data space above internal memory goes out on the EXT_ port
// Operation
// - I/O in and out, one cycle, flags kept
// - Push takes one cycle, flags kept
// - Pop takes two cycles, flags kept
// - Load-and-or returns old, writes OR
// - Load-and-clear returns old, writes AND-NOT
// - Load-and-xor returns old, writes XOR
// - Left rotate through carry, sets Z,C,N,V,H
// - Right rotate through carry, sets Z,C,N,V
// - I/O bit set, one cycle, flags kept
// - I/O bit clear, one cycle, flags kept
// - Register bit into transfer flag only
// - Transfer flag into register bit only
// - Overflow flag set or clear alone
// - Half-carry flag set or clear alone
// - Signed-test flag set or clear alone
// - Break issues in one cycle, flags kept
// - Sleep issues in one cycle, flags kept
// - Watchdog restart in one cycle, flags kept
// - External data space may take longer
// - Internal memory load costs one extra cycle
`timescale 1ns/1ps
`default_nettype none
module ctbce_core
    import ctbce_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    input  wire logic        OP_VALID,
    input  wire ctbce_op_t   OP_CODE,
    input  wire logic [4:0]  OP_REG,
    input  wire logic [2:0]  OP_BIT,
    input  wire logic [5:0]  OP_IO,
    output logic             OP_READY,
    output logic             OP_DONE,
    output logic [7:0]       STATUS,
    input  wire logic [4:0]  REG_SEL,
    output logic [7:0]       REG_DATA,
    output logic             IO_WR_STB,
    output logic [5:0]       IO_WR_ADDR,
    output logic [7:0]       IO_WR_DATA,
    output logic             EXT_REQ,
    output logic             EXT_WE,
    output logic [15:0]      EXT_ADDR,
    output logic [7:0]       EXT_WDATA,
    input  wire logic [7:0]  EXT_RDATA,
    input  wire logic        EXT_ACK,
    output logic             BREAK_REQ,
    output logic             SLEEP_REQ,
    output logic             WDT_RESTART
);
`include "ctbce_map.svh"

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    ctbce_state_t  state_r;
    ctbce_op_t     op_r;
    logic [4:0]    reg_r;
    logic [15:0]   addr_r;
    logic          ext_we_r;
    logic [7:0]    ext_wdata_r;
    logic [15:0]   sp_r;
    logic [7:0]    status_register_r;
    logic [7:0]    status_nxt;
    logic [7:0]    rf_r [0:`CTBCE_RF_DEPTH-1];
    logic [7:0]    io_r [0:`CTBCE_IO_DEPTH-1];
    logic          done_r;
    logic          io_stb_r;
    logic [5:0]    io_addr_r;
    logic [7:0]    io_data_r;
    logic [7:0]    reg_data_r;
    logic          break_r;
    logic          sleep_r;
    logic          wdt_r;

    logic          accept;
    logic [15:0]   z_ptr;
    logic [15:0]   iss_addr;
    logic          iss_int;
    logic          iss_rd;
    logic          op_rmw;
    logic [7:0]    src_val;
    logic [7:0]    held_val;
    logic [7:0]    mem_data;
    logic [7:0]    new_val;
    logic [7:0]    rot_val;
    logic          rot_c;
    logic          rf_we;
    logic [4:0]    rf_wa;
    logic [7:0]    rf_wd;
    logic          io_we;
    logic [7:0]    io_wd;
    logic          finish;

    ctbce_dm_if    dm ();

    ctbce_dmem u_dmem
    (
        .clk   (MCLK),
        .rst_n (NRST),
        .dm    (dm)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Issue decode
    assign OP_READY = (state_r == S_IDLE) && CE;
    assign accept   = OP_VALID && OP_READY;
    assign z_ptr    = {rf_r[`CTBCE_Z_HI], rf_r[`CTBCE_Z_LO]};
    assign src_val  = rf_r[OP_REG];
    assign held_val = rf_r[reg_r];
    assign iss_int  = iss_addr < `CTBCE_DM_INT_TOP;
    assign op_rmw   = (op_r == OP_LOAD_AND_OR_MEM) || (op_r == OP_LOAD_AND_CLEARBITS_MEM)
                      || (op_r == OP_LOAD_AND_XOR_MEM);

    assign iss_rd   = OP_CODE inside {OP_POP, OP_LOAD_Z, OP_LOAD_AND_OR_MEM, OP_LOAD_AND_CLEARBITS_MEM,
                                      OP_LOAD_AND_XOR_MEM};

    always_comb
    begin
        case (OP_CODE)
            OP_PUSH: iss_addr = sp_r;
            OP_POP:  iss_addr = sp_r + `CTBCE_ADDR_ONE;
            default: iss_addr = z_ptr;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data path
    assign mem_data = (state_r == S_EXT) ? EXT_RDATA : dm.rdata;

    always_comb
    begin
        case (op_r)
            OP_LOAD_AND_OR_MEM:        new_val = mem_data | held_val;
            OP_LOAD_AND_CLEARBITS_MEM: new_val = mem_data & ~held_val;
            OP_LOAD_AND_XOR_MEM:       new_val = mem_data ^ held_val;
            default:                   new_val = mem_data;
        endcase
    end

    always_comb
    begin
        if (OP_CODE == OP_ROTATE_LEFT_CARRY)
        begin
            rot_val = {src_val[6:0], status_register_r[`CTBCE_FLAG_C]};
            rot_c   = src_val[7];
        end
        else
        begin
            rot_val = {status_register_r[`CTBCE_FLAG_C], src_val[7:1]};
            rot_c   = src_val[0];
        end
    end

    assign dm.ce    = CE;
    assign dm.addr  = (state_r == S_IDLE) ? iss_addr[7:0] : addr_r[7:0];
    assign dm.re    = accept && iss_rd && iss_int;
    assign dm.we    = (accept && (OP_CODE == OP_PUSH) && iss_int)
                      || ((state_r == S_MEM) && op_rmw);
    assign dm.wdata = (state_r == S_IDLE) ? src_val : new_val;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            state_r     <= S_IDLE;
            op_r        <= OP_NOP;
            reg_r       <= 5'h00;
            addr_r      <= `CTBCE_ADDR_ZERO;
            ext_we_r    <= 1'b0;
            ext_wdata_r <= `CTBCE_BYTE_ZERO;
        end
        else if (CE)
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (accept && (iss_rd || (OP_CODE == OP_PUSH)))
                    begin
                        op_r        <= OP_CODE;
                        reg_r       <= OP_REG;
                        addr_r      <= iss_addr;
                        ext_we_r    <= !iss_rd;
                        ext_wdata_r <= src_val;
                        if (!iss_int)
                            state_r <= S_EXT;
                        else if (iss_rd)
                            state_r <= S_MEM;
                    end
                end
                S_MEM:   state_r <= S_IDLE;
                S_EXT:
                begin
                    if (EXT_ACK && !ext_we_r && op_rmw)
                    begin
                        ext_we_r    <= 1'b1;
                        ext_wdata_r <= new_val;
                    end
                    else if (EXT_ACK)
                        state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    assign EXT_REQ   = (state_r == S_EXT);
    assign EXT_WE    = ext_we_r;
    assign EXT_ADDR  = addr_r;
    assign EXT_WDATA = ext_wdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Stack pointer
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            sp_r <= `CTBCE_SP_RESET;
        end
        else if (CE && accept)
        begin
            if (OP_CODE == OP_PUSH)
                sp_r <= sp_r - `CTBCE_ADDR_ONE;
            else if (OP_CODE == OP_POP)
                sp_r <= iss_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb
    begin
        rf_we = 1'b0;
        rf_wa = OP_REG;
        rf_wd = src_val;
        if (accept)
        begin
            rf_we = OP_CODE inside {OP_IO_IN, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
                                    OP_TRANSFER_FLAG_TO_BIT};
            case (OP_CODE)
                OP_IO_IN:                rf_wd         = io_r[OP_IO];
                OP_TRANSFER_FLAG_TO_BIT: rf_wd[OP_BIT] = status_register_r[`CTBCE_FLAG_T];
                default:                 rf_wd         = rot_val;
            endcase
        end
        else if ((state_r == S_MEM) || ((state_r == S_EXT) && EXT_ACK && !ext_we_r))
        begin
            rf_we = 1'b1;
            rf_wa = reg_r;
            rf_wd = mem_data;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (CE && rf_we)
        begin
            rf_r[rf_wa] <= rf_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // I/O space
    always_comb
    begin
        io_we = 1'b0;
        io_wd = io_r[OP_IO];
        if (accept)
        begin
            io_we = OP_CODE inside {OP_IO_OUT, OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
            case (OP_CODE)
                OP_IO_BIT_SET:   io_wd[OP_BIT] = 1'b1;
                OP_IO_BIT_CLEAR: io_wd[OP_BIT] = 1'b0;
                default:         io_wd         = src_val;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (CE && io_we)
        begin
            io_r[OP_IO] <= io_wd;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            io_stb_r  <= 1'b0;
            io_addr_r <= 6'h00;
            io_data_r <= `CTBCE_BYTE_ZERO;
        end
        else if (CE)
        begin
            io_stb_r <= io_we;
            if (io_we)
            begin
                io_addr_r <= OP_IO;
                io_data_r <= io_wd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status register
    always_comb
    begin
        status_nxt = status_register_r;
        case (OP_CODE)
            OP_ROTATE_LEFT_CARRY:
            begin
                status_nxt[`CTBCE_FLAG_C] = rot_c;
                status_nxt[`CTBCE_FLAG_Z] = (rot_val == `CTBCE_BYTE_ZERO);
                status_nxt[`CTBCE_FLAG_N] = rot_val[7];
                status_nxt[`CTBCE_FLAG_V] = rot_val[7] ^ rot_c;
                status_nxt[`CTBCE_FLAG_H] = src_val[3];
            end
            OP_ROTATE_RIGHT_CARRY:
            begin
                status_nxt[`CTBCE_FLAG_C] = rot_c;
                status_nxt[`CTBCE_FLAG_Z] = (rot_val == `CTBCE_BYTE_ZERO);
                status_nxt[`CTBCE_FLAG_N] = rot_val[7];
                status_nxt[`CTBCE_FLAG_V] = rot_val[7] ^ rot_c;
            end
            OP_BIT_TO_TRANSFER_FLAG:  status_nxt[`CTBCE_FLAG_T] = src_val[OP_BIT];
            OP_OVERFLOW_FLAG_SET:     status_nxt[`CTBCE_FLAG_V] = 1'b1;
            OP_OVERFLOW_FLAG_CLEAR:   status_nxt[`CTBCE_FLAG_V] = 1'b0;
            OP_HALFCARRY_SET:         status_nxt[`CTBCE_FLAG_H] = 1'b1;
            OP_HALFCARRY_CLEAR:       status_nxt[`CTBCE_FLAG_H] = 1'b0;
            OP_SIGNTEST_SET:          status_nxt[`CTBCE_FLAG_S] = 1'b1;
            OP_SIGNTEST_CLEAR:        status_nxt[`CTBCE_FLAG_S] = 1'b0;
            OP_FLAG_SET:              status_nxt[OP_BIT] = 1'b1;
            OP_FLAG_CLEAR:            status_nxt[OP_BIT] = 1'b0;
            default:                  status_nxt = status_register_r;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            status_register_r <= `CTBCE_STATUS_RESET;
        end
        else if (CE && accept)
        begin
            status_register_r <= status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Completion and control pulses
    assign finish = (accept && !iss_rd && !((OP_CODE == OP_PUSH) && !iss_int))
                    || (state_r == S_MEM)
                    || ((state_r == S_EXT) && EXT_ACK && (ext_we_r || !op_rmw));

    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            done_r     <= 1'b0;
            break_r    <= 1'b0;
            sleep_r    <= 1'b0;
            wdt_r      <= 1'b0;
            reg_data_r <= `CTBCE_BYTE_ZERO;
        end
        else if (CE)
        begin
            done_r     <= finish;
            break_r    <= accept && (OP_CODE == OP_BREAK);
            sleep_r    <= accept && (OP_CODE == OP_SLEEP);
            wdt_r      <= accept && (OP_CODE == OP_WATCHDOG_RESTART);
            reg_data_r <= rf_r[REG_SEL];
        end
    end

    assign OP_DONE     = done_r;
    assign STATUS      = status_register_r;
    assign REG_DATA    = reg_data_r;
    assign IO_WR_STB   = io_stb_r;
    assign IO_WR_ADDR  = io_addr_r;
    assign IO_WR_DATA  = io_data_r;
    assign BREAK_REQ   = break_r;
    assign SLEEP_REQ   = sleep_r;
    assign WDT_RESTART = wdt_r;

endmodule : ctbce_core
`default_nettype wire

// ==== ctbce_core_monitor.sv ====
// Purpose: Port checks of the execution unit
// Assumes: One clock, reset low active
// Notes:   Bound to the core after the module
`timescale 1ns/1ps
`default_nettype none
module ctbce_core_monitor
    import ctbce_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        NRST,
    input wire logic        OP_VALID,
    input wire ctbce_op_t   OP_CODE,
    input wire logic [5:0]  OP_IO,
    input wire logic        OP_READY,
    input wire logic        OP_DONE,
    input wire logic [7:0]  STATUS,
    input wire logic        IO_WR_STB,
    input wire logic [5:0]  IO_WR_ADDR,
    input wire logic        EXT_REQ,
    input wire logic [15:0] EXT_ADDR,
    input wire logic        EXT_ACK,
    input wire logic        BREAK_REQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    logic tk;
    assign tk = OP_VALID && OP_READY;
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    property p_keep;
        tk && OP_CODE inside {OP_IO_IN, OP_IO_OUT, OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_TRANSFER_FLAG_TO_BIT,
            OP_BREAK, OP_SLEEP, OP_WATCHDOG_RESTART} |=> OP_DONE && $stable(STATUS);
    endproperty
    a_keep: assert property (p_keep) else $error("flags moved");
    property p_ovf;
        tk && OP_CODE inside {OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR} |=> STATUS ==
            (($past(STATUS) & 8'hF7) | (($past(OP_CODE) == OP_OVERFLOW_FLAG_SET) ? 8'h08 : 8'h00));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag op");
    property p_half;
        tk && OP_CODE inside {OP_HALFCARRY_SET, OP_HALFCARRY_CLEAR} |=> STATUS ==
            (($past(STATUS) & 8'hDF) | (($past(OP_CODE) == OP_HALFCARRY_SET) ? 8'h20 : 8'h00));
    endproperty
    a_half: assert property (p_half) else $error("half carry op");
    property p_sign;
        tk && OP_CODE inside {OP_SIGNTEST_SET, OP_SIGNTEST_CLEAR} |=> STATUS ==
            (($past(STATUS) & 8'hEF) | (($past(OP_CODE) == OP_SIGNTEST_SET) ? 8'h10 : 8'h00));
    endproperty
    a_sign: assert property (p_sign) else $error("sign test op");
    property p_bst;
        tk && OP_CODE == OP_BIT_TO_TRANSFER_FLAG |=> (STATUS & 8'hBF) == ($past(STATUS) & 8'hBF);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store flags");
    property p_rol;
        tk && OP_CODE == OP_ROTATE_LEFT_CARRY |=> (STATUS & 8'hD0) == ($past(STATUS) & 8'hD0)
            && STATUS[3] == (STATUS[2] ^ STATUS[0]) && !(STATUS[1] && STATUS[2]);
    endproperty
    a_rol: assert property (p_rol) else $error("left rotate flags");
    property p_ror;
        tk && OP_CODE == OP_ROTATE_RIGHT_CARRY |=> (STATUS & 8'hF0) == ($past(STATUS) & 8'hF0)
            && STATUS[3] == (STATUS[2] ^ STATUS[0]) && !(STATUS[1] && STATUS[2]);
    endproperty
    a_ror: assert property (p_ror) else $error("right rotate flags");
    property p_brk;
        tk && OP_CODE == OP_BREAK |=> s_pulse(BREAK_REQ);
    endproperty
    a_brk: assert property (p_brk) else $error("break pulse");
    property p_out;
        tk && OP_CODE == OP_IO_OUT |=> IO_WR_STB && IO_WR_ADDR == $past(OP_IO);
    endproperty
    a_out: assert property (p_out) else $error("io write");
    property p_ext;
        EXT_REQ && !EXT_ACK |=> EXT_REQ && $stable(EXT_ADDR);
    endproperty
    a_ext: assert property (p_ext) else $error("external request dropped");
endmodule : ctbce_core_monitor
bind ctbce_core ctbce_core_monitor u_mon (.MCLK, .NRST, .OP_VALID, .OP_CODE, .OP_IO, .OP_READY, .OP_DONE,
    .STATUS, .IO_WR_STB, .IO_WR_ADDR, .EXT_REQ, .EXT_ADDR, .EXT_ACK, .BREAK_REQ);
`default_nettype wire

// ==== ctbce_ext_mem.sv ====
// Purpose: External data space responder
// Assumes: Requests held until acknowledged
// Notes:   Random wait of zero to three cycles per phase
`timescale 1ns/1ps
`default_nettype none
module ctbce_ext_mem
(
    input  wire logic        MCLK,
    input  wire logic        EXT_REQ,
    input  wire logic        EXT_WE,
    input  wire logic [15:0] EXT_ADDR,
    input  wire logic [7:0]  EXT_WDATA,
    output logic [7:0]       EXT_RDATA,
    output logic             EXT_ACK
);
    logic [7:0]  mem [256];
    logic [1:0]  wait_r;
    logic [31:0] seed_r;
    initial
    begin
        seed_r    = 32'h00001357;
        EXT_ACK   = 1'h0;
        EXT_RDATA = 8'h00;
        wait_r    = 2'h1;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5A;
    end
    always @(posedge MCLK)
    begin
        // Read data toggles outside an answer
        EXT_RDATA <= ~EXT_RDATA;
        if (EXT_ACK)
        begin
            EXT_ACK <= 1'h0;
            if (EXT_WE)
                mem[EXT_ADDR[7:0]] <= EXT_WDATA;
            wait_r <= 2'($random(seed_r));
        end
        else if (EXT_REQ && wait_r != 2'h0)
            wait_r <= wait_r - 2'h1;
        else if (EXT_REQ)
        begin
            EXT_ACK   <= 1'h1;
            EXT_RDATA <= mem[EXT_ADDR[7:0]];
        end
    end
endmodule : ctbce_ext_mem
`default_nettype wire

// ==== cpu_transfer_bit_control_exec_tb.sv ====
// Purpose: Self-checking bench of the execution unit
// Assumes: Clock enable held high
// Notes:   Registers loaded bit by bit through the transfer flag
`timescale 1ns/1ps
`default_nettype none
module cpu_transfer_bit_control_exec_tb;
    import ctbce_pkg::*;
    logic        MCLK, NRST, CE, OP_VALID, OP_READY, OP_DONE, IO_WR_STB;
    logic        EXT_REQ, EXT_WE, EXT_ACK, BREAK_REQ, SLEEP_REQ, WDT_RESTART;
    ctbce_op_t   OP_CODE, fop [6], mop [3];
    logic [4:0]  OP_REG, REG_SEL;
    logic [2:0]  OP_BIT, b;
    logic [5:0]  OP_IO, IO_WR_ADDR, a;
    logic [7:0]  STATUS, REG_DATA, IO_WR_DATA, EXT_WDATA, EXT_RDATA, st_exp, v, w, m;
    logic [15:0] EXT_ADDR, q;
    logic [31:0] seed;
    int          miscompares, samples_checked, cycles, cyc;
    ctbce_core u_dut (.MCLK, .NRST, .CE, .OP_VALID, .OP_CODE, .OP_REG, .OP_BIT, .OP_IO, .OP_READY, .OP_DONE,
        .STATUS, .REG_SEL, .REG_DATA, .IO_WR_STB, .IO_WR_ADDR, .IO_WR_DATA, .EXT_REQ, .EXT_WE, .EXT_ADDR,
        .EXT_WDATA, .EXT_RDATA, .EXT_ACK, .BREAK_REQ, .SLEEP_REQ, .WDT_RESTART);
    ctbce_ext_mem u_ext (.MCLK, .EXT_REQ, .EXT_WE, .EXT_ADDR, .EXT_WDATA, .EXT_RDATA, .EXT_ACK);
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input ctbce_op_t c, input logic [4:0] r, input logic [2:0] bt, input logic [5:0] io,
                      input int ncyc);
        OP_VALID <= 1'h1;
        OP_CODE  <= c;
        OP_REG   <= r;
        OP_BIT   <= bt;
        OP_IO    <= io;
        do @(posedge MCLK); while (OP_READY !== 1'h1);
        OP_VALID <= 1'h0;
        cycles = 0;
        do
        begin
            @(posedge MCLK);
            cycles++;
        end
        while (OP_DONE !== 1'h1 && cycles < 40);
        if (ncyc > 0)
            chk(16'(cycles), 16'(ncyc));
        chk(STATUS, st_exp);
    endtask : op
    task automatic rd(input logic [4:0] r, input logic [7:0] exp);
        REG_SEL <= r;
        repeat (2) @(posedge MCLK);
        chk(REG_DATA, exp);
    endtask : rd
    task automatic set_reg(input logic [4:0] r, input logic [7:0] val);
        for (int i = 0; i < 8; i++)
        begin
            st_exp[6] = val[i];
            op(val[i] ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 3'h6, 6'h00, 1);
            op(OP_TRANSFER_FLAG_TO_BIT, r, 3'(i), 6'h00, 1);
        end
    endtask : set_reg
    function automatic logic [15:0] rot(input logic [7:0] x, input logic [7:0] s, input logic left);
        logic [7:0] r;
        logic [7:0] f;
        r = left ? {x[6:0], s[0]} : {s[0], x[7:1]};
        f = s;
        f[0] = left ? x[7] : x[0];
        f[1] = (r == 8'h00);
        f[2] = r[7];
        f[3] = r[7] ^ f[0];
        if (left)
            f[5] = x[3];
        return {r, f};
    endfunction : rot
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        MCLK = 1'h0;
        forever #25 MCLK = ~MCLK;
    end
    always @(posedge MCLK)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            miscompares++;
            close_out;
        end
    end
    initial
    begin
        seed = 32'h06AC70CC;
        {NRST, OP_VALID, OP_REG, OP_BIT, OP_IO, REG_SEL, st_exp} = '0;
        CE = 1'h1;
        OP_CODE = OP_NOP;
        fop = '{OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR, OP_SIGNTEST_SET, OP_SIGNTEST_CLEAR,
                OP_HALFCARRY_SET, OP_HALFCARRY_CLEAR};
        mop = '{OP_LOAD_AND_OR_MEM, OP_LOAD_AND_CLEARBITS_MEM, OP_LOAD_AND_XOR_MEM};
        repeat (6) @(posedge MCLK);
        chk({STATUS, REG_DATA}, 16'h0000);
        chk({IO_WR_STB, EXT_REQ, BREAK_REQ, SLEEP_REQ, WDT_RESTART}, 16'h0000);
        NRST <= 1'h1;
        for (int i = 0; i < 12; i++)
        begin
            b = 3'($random(seed));
            v = 8'($random(seed));
            st_exp[b] = v[0];
            op(v[0] ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, b, 6'h00, 1);
            w = 8'h08 << ((i % 6) / 2);
            st_exp = i[0] ? (st_exp & ~w) : (st_exp | w);
            op(fop[i % 6], 5'h00, b, 6'h00, 1);
        end
        for (int i = 0; i < 16; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($random(seed));
            a = 6'($random(seed));
            b = 3'($random(seed));
            set_reg(5'(i), v);
            st_exp[0] = (i > 1) & v[1];
            op(st_exp[0] ? OP_FLAG_SET : OP_FLAG_CLEAR, 5'h00, 3'h0, a, 1);
            q = rot(v, st_exp, !i[0]);
            st_exp = q[7:0];
            op(i[0] ? OP_ROTATE_RIGHT_CARRY : OP_ROTATE_LEFT_CARRY, 5'(i), b, a, 1);
            rd(5'(i), q[15:8]);
            st_exp[6] = q[8 + b];
            op(OP_BIT_TO_TRANSFER_FLAG, 5'(i), b, a, 1);
            op(OP_IO_OUT, 5'(i), b, a, 1);
            chk({IO_WR_STB, 1'h0, IO_WR_ADDR, IO_WR_DATA}, {2'h2, a, q[15:8]});
            w = i[1] ? (q[15:8] | (8'h01 << b)) : (q[15:8] & ~(8'h01 << b));
            op(i[1] ? OP_IO_BIT_SET : OP_IO_BIT_CLEAR, 5'(i), b, a, 1);
            chk({IO_WR_STB, 1'h0, IO_WR_ADDR, IO_WR_DATA}, {2'h2, a, w});
            op(OP_IO_IN, 5'(i + 16), b, a, 1);
            rd(5'(i + 16), w);
        end
        set_reg(5'h1F, 8'h00);
        set_reg(5'h1E, 8'hFF);
        for (int k = 0; k < 3; k++)
        begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            set_reg(5'h01, v);
            set_reg(5'h02, w);
            op(OP_PUSH, 5'h01, 3'h0, 6'h00, 1);
            m = (k == 0) ? (v | w) : (k == 1) ? (v & ~w) : (v ^ w);
            op(mop[k], 5'h02, 3'h0, 6'h00, 2);
            rd(5'h02, v);
            op(OP_LOAD_Z, 5'h03, 3'h0, 6'h00, 2);
            rd(5'h03, m);
            op(OP_POP, 5'h04, 3'h0, 6'h00, 2);
            rd(5'h04, m);
        end
        set_reg(5'h1F, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            v = 8'($random(seed));
            q = 16'($random(seed));
            w = u_ext.mem[v];
            set_reg(5'h1E, v);
            set_reg(5'h02, q[7:0]);
            m = (k == 0) ? (w | q[7:0]) : (k == 1) ? (w & ~q[7:0]) : (w ^ q[7:0]);
            op(mop[k], 5'h02, 3'h0, 6'h00, 0);
            rd(5'h02, w);
            chk(u_ext.mem[v], m);
        end
        op(OP_BREAK, 5'h00, 3'h0, 6'h00, 1);
        chk(BREAK_REQ, 1'h1);
        op(OP_SLEEP, 5'h00, 3'h0, 6'h00, 1);
        chk(SLEEP_REQ, 1'h1);
        op(OP_WATCHDOG_RESTART, 5'h00, 3'h0, 6'h00, 1);
        chk(WDT_RESTART, 1'h1);
        close_out;
    end
endmodule : cpu_transfer_bit_control_exec_tb
`default_nettype wire
